// >>> include/sdc_pkg.sv
// shared constants, command codes and carrier types of the sdram pin interface
package sdc_pkg;
  localparam int DQ_W = 16;
  localparam int ADDR_W = 12;
  localparam int BA_W = 2;
  localparam int NBANK = 4;
  localparam int COL_W = 8;
  localparam int ROW_KEEP = 2;
  localparam int MEM_AW = BA_W + ROW_KEEP + COL_W;
  localparam int MEM_WORDS = 1 << MEM_AW;
  localparam int FIFO_DEPTH = 16;
  localparam int PREFLAG_BIT = 10;
  localparam int MR_BL_LSB = 0;
  localparam int MR_CL_LSB = 4;
  localparam logic [2:0] MR_BL_FULL = 3'h7;
  localparam logic [1:0] MR_CL_THREE = 2'h3;
  localparam logic [ADDR_W-1:0] MODE_RESET = 12'h020;
  localparam logic [8:0] FULL_PAGE_LEN = 9'h100;
  localparam int PIPE_DEPTH = 2;
  // command codes on {chip select, row strobe, column strobe, write enable}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_TERM = 4'h6;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_LOAD_MODE = 4'h0;

  typedef enum logic [2:0] {
    PS_RUN, PS_PRE_PD, PS_ACT_PD, PS_SUSPEND, PS_SELF_REF
  } sdc_pwr_t;

  typedef struct packed {
    logic chip_select_n;
    logic row_strobe_n;
    logic column_strobe_n;
    logic write_enable_n;
  } sdc_cmd_t;

  typedef struct packed {
    logic clock_enable;
    sdc_cmd_t cmd;
    logic [BA_W-1:0] bank_select;
    logic [ADDR_W-1:0] addr_bus;
    logic [1:0] byte_mask;
    logic [DQ_W-1:0] dq;
  } sdc_pins_t;

  typedef struct packed {
    logic [MEM_AW-1:0] addr;
    logic [DQ_W-1:0] data;
    logic [1:0] mask;
  } sdc_beat_t;
endpackage

// >>> logic/sdc_fifo.sv
// parameterised valid/ready fifo for write beats
`timescale 1ns/1ps
module sdc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  // full and empty come straight from the occupancy count
  assign in_ready = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = store[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointers wrap naturally since depth is a power of two
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // storage has no reset, only written slots are ever read
  always_ff @(posedge clk) begin
    if (push) store[wr_ptr] <= in_data;
  end
endmodule

// >>> logic/sdc_device.sv
// sdram device side: pin command decode, bank state, bursts, masks and power states
`timescale 1ns/1ps
module sdc_device (
  input wire logic clk,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_enable_n,
  input wire logic [sdc_pkg::BA_W-1:0] bank_select,
  input wire logic [sdc_pkg::ADDR_W-1:0] addr_bus,
  input wire logic low_byte_mask,
  input wire logic high_byte_mask,
  input wire logic [sdc_pkg::DQ_W-1:0] dq_in,
  output logic [sdc_pkg::DQ_W-1:0] dq_out,
  output logic [1:0] dq_oe,
  output sdc_pkg::sdc_pwr_t power_state,
  output logic input_buffers_off,
  output logic [sdc_pkg::ADDR_W-1:0] mode_reg,
  output logic [sdc_pkg::NBANK-1:0] bank_open
);
  import sdc_pkg::*;

  // burst length from the mode register field
  function automatic logic [8:0] sdc_burst_len(input logic [ADDR_W-1:0] mr);
    logic [2:0] f;
    f = mr[MR_BL_LSB +: 3];
    if (f == MR_BL_FULL) return FULL_PAGE_LEN;
    return 9'(9'h1 << f[1:0]);
  endfunction

  // storage index: bank, low row bits and column
  function automatic logic [MEM_AW-1:0] sdc_index(input logic [BA_W-1:0] b,
      input logic [ADDR_W-1:0] r, input logic [COL_W-1:0] c);
    return {b, r[ROW_KEEP-1:0], c};
  endfunction

  sdc_pins_t pins_raw;
  sdc_pins_t pins_meta;
  sdc_pins_t pins_s;
  logic run;
  logic cmd_ok;
  logic [3:0] cmd;
  logic [ADDR_W-1:0] open_row [NBANK];
  logic bact;
  logic bwr;
  logic bauto;
  logic [BA_W-1:0] bbank;
  logic [COL_W-1:0] bcol;
  logic [8:0] bleft;
  logic is_rw;
  logic beat;
  logic beat_wr;
  logic beat_last;
  logic beat_auto;
  logic [BA_W-1:0] beat_bank;
  logic [COL_W-1:0] beat_col;
  logic stall;
  logic [8:0] len;
  sdc_beat_t wbeat;
  sdc_beat_t dbeat;
  logic fifo_ready;
  logic fifo_valid;
  logic [DQ_W-1:0] mem [MEM_WORDS];
  logic [PIPE_DEPTH-1:0] pv;
  logic [DQ_W-1:0] pd [PIPE_DEPTH];
  logic [1:0] mask_q;
  logic tap;

  assign pins_raw = '{clock_enable, '{chip_select_n, row_strobe_n, column_strobe_n,
    write_enable_n}, bank_select, addr_bus, {high_byte_mask, low_byte_mask}, dq_in};

  // two-stage capture of every pin; only the second stage is read
  always_ff @(posedge clk) begin
    pins_meta <= pins_raw;
    pins_s <= pins_meta;
  end

  // internal clocking follows clock_enable; tying it high keeps everything running
  assign run = pins_s.clock_enable;
  assign cmd = pins_s.cmd;
  assign cmd_ok = run && !pins_s.cmd.chip_select_n;
  assign is_rw = cmd_ok && (cmd == CMD_READ || cmd == CMD_WRITE);
  assign len = sdc_burst_len(mode_reg);

  // the current beat comes from a new command or from the running burst
  always_comb begin
    beat = 1'b0;
    beat_wr = bwr;
    beat_bank = bbank;
    beat_col = bcol;
    beat_auto = bauto;
    beat_last = (bleft == 9'h1);
    if (is_rw) begin
      beat = 1'b1;
      beat_wr = (cmd == CMD_WRITE);
      beat_bank = pins_s.bank_select;
      beat_col = pins_s.addr_bus[COL_W-1:0];
      beat_auto = pins_s.addr_bus[PREFLAG_BIT];
      beat_last = (len == 9'h1);
    end else if (run && bact) begin
      beat = 1'b1;
    end
  end

  // a full write buffer freezes the burst rather than losing data
  assign stall = beat && beat_wr && !fifo_ready;

  // burst counter: start, step, terminate, and self-timed close
  always_ff @(posedge clk) begin
    if (rst) begin
      bact <= 1'b0;
      bwr <= 1'b0;
      bauto <= 1'b0;
      bbank <= '0;
      bcol <= '0;
      bleft <= '0;
    end else if (!stall) begin
      if (is_rw) begin
        bact <= (len != 9'h1);
        bwr <= beat_wr;
        bauto <= beat_auto;
        bbank <= beat_bank;
        bcol <= COL_W'(beat_col + 1'b1);
        bleft <= len - 9'h1;
      end else if (cmd_ok && cmd == CMD_TERM) begin
        bact <= 1'b0;
      end else if (beat) begin
        bcol <= COL_W'(bcol + 1'b1);
        bleft <= bleft - 9'h1;
        if (beat_last) bact <= 1'b0;
      end
    end
  end

  // row state per bank; auto precharge closes the row when the last beat goes
  always_ff @(posedge clk) begin
    if (rst) begin
      bank_open <= '0;
      for (int i = 0; i < NBANK; i++) open_row[i] <= '0;
    end else begin
      if (beat && !stall && beat_last && beat_auto)
        bank_open[beat_bank] <= 1'b0;
      if (cmd_ok && cmd == CMD_ACTIVE) begin
        bank_open[pins_s.bank_select] <= 1'b1;
        open_row[pins_s.bank_select] <= pins_s.addr_bus;
      end else if (cmd_ok && cmd == CMD_PRECHARGE) begin
        if (pins_s.addr_bus[PREFLAG_BIT]) bank_open <= '0;
        else bank_open[pins_s.bank_select] <= 1'b0;
      end
    end
  end

  // mode register load
  always_ff @(posedge clk) begin
    if (rst) mode_reg <= MODE_RESET;
    else if (cmd_ok && cmd == CMD_LOAD_MODE) mode_reg <= pins_s.addr_bus;
  end

  // write beats queue up and drain into the array only while clocking runs
  assign wbeat = '{sdc_index(beat_bank, open_row[beat_bank], beat_col),
    pins_s.dq, pins_s.byte_mask};

  sdc_fifo #(
    .WIDTH($bits(sdc_beat_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_wbuf (
    .clk(clk),
    .rst(rst),
    .in_valid(beat && beat_wr),
    .in_ready(fifo_ready),
    .in_data(wbeat),
    .out_valid(fifo_valid),
    .out_ready(run),
    .out_data(dbeat)
  );

  // masked byte lanes leave the stored byte untouched
  always_ff @(posedge clk) begin
    if (fifo_valid && run) begin
      for (int g = 0; g < 2; g++) begin
        if (!dbeat.mask[g]) mem[dbeat.addr][g*8 +: 8] <= dbeat.data[g*8 +: 8];
      end
    end
  end

  // read pipeline; holds still in clock suspend so data waits with the burst
  always_ff @(posedge clk) begin
    if (rst) begin
      pv <= '0;
      for (int i = 0; i < PIPE_DEPTH; i++) pd[i] <= '0;
    end else if (run) begin
      pv[0] <= beat && !beat_wr;
      pd[0] <= mem[sdc_index(beat_bank, open_row[beat_bank], beat_col)];
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pv[i] <= pv[i-1];
        pd[i] <= pd[i-1];
      end
    end
  end

  // latency 3 uses the later stage; any other setting behaves as latency 2
  assign tap = (mode_reg[MR_CL_LSB +: 2] == MR_CL_THREE);

  // byte mask is sampled regardless of chip select
  always_ff @(posedge clk) begin
    if (rst) mask_q <= '0;
    else mask_q <= pins_s.byte_mask;
  end

  // output registers; mask seen at one edge blanks the lane at the next-but-one
  always_ff @(posedge clk) begin
    if (rst) begin
      dq_out <= '0;
      dq_oe <= '0;
    end else if (run) begin
      dq_out <= pd[tap];
      for (int g = 0; g < 2; g++) dq_oe[g] <= pv[tap] && !mask_q[g];
    end
  end

  // power state machine; exit is watched every cycle whatever the state
  always_ff @(posedge clk) begin
    if (rst) begin
      power_state <= PS_RUN;
      input_buffers_off <= 1'b0;
    end else begin
      unique case (power_state)
        PS_RUN: begin
          if (!pins_s.clock_enable) begin
            if (!pins_s.cmd.chip_select_n && cmd == CMD_REFRESH && bank_open == '0) begin
              power_state <= PS_SELF_REF;
              input_buffers_off <= 1'b1;
            end else if (bact) begin
              power_state <= PS_SUSPEND;
            end else if (bank_open != '0) begin
              power_state <= PS_ACT_PD;
              input_buffers_off <= 1'b1;
            end else begin
              power_state <= PS_PRE_PD;
              input_buffers_off <= 1'b1;
            end
          end
        end
        PS_PRE_PD, PS_ACT_PD, PS_SELF_REF, PS_SUSPEND: begin
          if (pins_s.clock_enable) begin
            power_state <= PS_RUN;
            input_buffers_off <= 1'b0;
          end
        end
      endcase
    end
  end
endmodule

// >>> verification/sdc_device_checker.sv
// pin-level assertions for the sdram device, bound into it
`timescale 1ns/1ps
module sdc_device_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_enable_n,
  input wire logic [sdc_pkg::BA_W-1:0] bank_select,
  input wire logic [sdc_pkg::ADDR_W-1:0] addr_bus,
  input wire logic low_byte_mask,
  input wire logic high_byte_mask,
  input wire logic [1:0] dq_oe,
  input wire sdc_pkg::sdc_pwr_t power_state,
  input wire logic input_buffers_off,
  input wire logic [sdc_pkg::ADDR_W-1:0] mode_reg,
  input wire logic [sdc_pkg::NBANK-1:0] bank_open
);
  import sdc_pkg::*;
  logic [3:0] pin_cmd;
  // pins pass two sync flops, so an effect is sampled three edges after its pin
  assign pin_cmd = {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n};
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  // a command only counts with clock enable high on its own cycle and the two cycles before it
  sequence taken_s(logic [3:0] c);
    clock_enable[*3] ##0 pin_cmd == c;
  endsequence
  a_act_opens_bank: assert property (
    taken_s(CMD_ACTIVE) |-> ##3 bank_open[$past(bank_select, 3)])
    else $error("active did not open its bank");
  a_open_needs_act: assert property (
    |(bank_open & ~$past(bank_open)) |-> $past(pin_cmd, 3) == CMD_ACTIVE)
    else $error("bank opened without an active");
  a_pre_one_bank: assert property (
    taken_s(CMD_PRECHARGE) ##0 !addr_bus[PREFLAG_BIT] |-> ##3 !bank_open[$past(bank_select, 3)])
    else $error("precharge left its bank open");
  a_pre_all_banks: assert property (
    taken_s(CMD_PRECHARGE) ##0 addr_bus[PREFLAG_BIT] |-> ##3 bank_open == 4'h0)
    else $error("precharge all left a bank open");
  a_mode_load: assert property (
    taken_s(CMD_LOAD_MODE) |-> ##3 mode_reg == $past(addr_bus, 3))
    else $error("mode register did not take the op code");
  a_deselect_mode: assert property (
    chip_select_n |-> ##3 $stable(mode_reg))
    else $error("mode register changed on a deselected cycle");
  a_mask_hiz: assert property (
    clock_enable && (low_byte_mask || high_byte_mask) ##1 clock_enable
    |-> ##3 (dq_oe & $past({high_byte_mask, low_byte_mask}, 4)) == 2'h0)
    else $error("masked lane still driven");
  a_run_on_cke: assert property (
    clock_enable |-> ##3 power_state == PS_RUN)
    else $error("device not running with clock enable high");
  a_stop_on_low: assert property (
    !clock_enable |-> ##3 power_state != PS_RUN)
    else $error("device still running with clock enable low");
  a_buffers_off: assert property (
    input_buffers_off == (power_state inside {PS_PRE_PD, PS_ACT_PD, PS_SELF_REF}))
    else $error("input buffer state disagrees with power state");
endmodule

bind sdc_device sdc_device_checker sdc_device_checker_i (.clk(clk), .rst(rst),
  .clock_enable(clock_enable), .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
  .column_strobe_n(column_strobe_n), .write_enable_n(write_enable_n),
  .bank_select(bank_select), .addr_bus(addr_bus), .low_byte_mask(low_byte_mask),
  .high_byte_mask(high_byte_mask), .dq_oe(dq_oe), .power_state(power_state),
  .input_buffers_off(input_buffers_off), .mode_reg(mode_reg), .bank_open(bank_open));

// >>> verification/sdc_ctrl_model.sv
// controller-side model: drives command, address, mask and write data pins
`timescale 1ns/1ps
module sdc_ctrl_model (
  input wire logic clk,
  output sdc_pkg::sdc_pins_t pins
);
  import sdc_pkg::*;
  // idle: clock enable held high, no operation on the strobes
  initial pins = {1'b1, CMD_NOP, {(BA_W + ADDR_W + 2 + DQ_W){1'b0}}};
  // one command per call, held one cycle; clock enable stays as given
  task automatic cmd(input logic k, input logic [3:0] c, input logic [BA_W-1:0] b,
      input logic [ADDR_W-1:0] a, input logic [1:0] m, input logic [DQ_W-1:0] d);
    @(negedge clk);
    pins.clock_enable = k;
    pins.cmd = c;
    pins.bank_select = b;
    pins.addr_bus = a;
    pins.byte_mask = m;
    pins.dq = d;
    @(negedge clk);
    pins.cmd = CMD_NOP;
    // released bank, address and data lines show the inverse so stale values never pass; the mask returns to zero
    pins.bank_select = ~b;
    pins.addr_bus = ~a;
    pins.byte_mask = 2'h0;
    pins.dq = ~d;
  endtask
endmodule

// >>> verification/sdc_device_tb_top.sv
// self-checking bench for the sdram pin command interface
`timescale 1ns/1ps
`define CHK(g, w) begin num_checks++; if ((g) !== (w)) begin n_fail++; \
  $display("unexpected at %0t: got %0h want %0h", $time, g, w); end end
module sdc_device_tb_top;
  import sdc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sdc_pins_t pins;
  logic [DQ_W-1:0] dq_in, dq_out, d;
  logic [DQ_W-1:0] mem [8];
  logic [1:0] dq_oe, b, m;
  logic [2:0] c;
  logic bufs_off, wr;
  logic [ADDR_W-1:0] mode_reg, op, row, a;
  logic [NBANK-1:0] bank_open;
  sdc_pwr_t power_state;
  sdc_pwr_t pst [3];
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int unsigned seed;

  always #12.5 clk = ~clk;
  // shared data wire: device lane when it drives, controller otherwise
  assign dq_in = {dq_oe[1] ? dq_out[15:8] : pins.dq[15:8], dq_oe[0] ? dq_out[7:0] : pins.dq[7:0]};

  sdc_ctrl_model sdc_ctrl_model_i (.clk(clk), .pins(pins));
  sdc_device sdc_device_i (.clk(clk), .rst(rst), .clock_enable(pins.clock_enable),
    .chip_select_n(pins.cmd.chip_select_n), .row_strobe_n(pins.cmd.row_strobe_n),
    .column_strobe_n(pins.cmd.column_strobe_n), .write_enable_n(pins.cmd.write_enable_n),
    .bank_select(pins.bank_select), .addr_bus(pins.addr_bus),
    .low_byte_mask(pins.byte_mask[0]), .high_byte_mask(pins.byte_mask[1]), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .power_state(power_state), .input_buffers_off(bufs_off),
    .mode_reg(mode_reg), .bank_open(bank_open));

  // lanes kept by a mask: a set mask bit keeps the old byte
  function automatic logic [DQ_W-1:0] lanes(input logic [1:0] k);
    return {{8{k[1]}}, {8{k[0]}}};
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard: the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    seed = $urandom(32'hD364);
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(mode_reg, MODE_RESET)
    `CHK(bank_open, 4'h0)
    `CHK(power_state, PS_RUN)
    // deselected load first, then a real one; burst 1 and latency 2 kept
    op = MODE_RESET | (12'($urandom) & 12'hF88);
    for (int i = 0; i < 2; i++) begin
      sdc_ctrl_model_i.cmd(1'b1, CMD_LOAD_MODE | {i == 0, 3'h0}, 2'h0, op, 2'h0, 16'h0);
      repeat (3) @(negedge clk);
      `CHK(mode_reg, i == 0 ? MODE_RESET : op)
    end
    b = 2'($urandom);
    row = 12'($urandom);
    sdc_ctrl_model_i.cmd(1'b1, CMD_ACTIVE | 4'h8, b ^ 2'h1, row, 2'h0, 16'h0);
    sdc_ctrl_model_i.cmd(1'b1, CMD_ACTIVE, b, row, 2'h0, 16'h0);
    repeat (3) @(negedge clk);
    `CHK(bank_open, 4'h1 << b)
    // fill eight columns, then random masked writes and reads
    for (int i = 0; i < 68; i++) begin
      c = i < 8 ? 3'(i) : 3'($urandom);
      d = 16'($urandom);
      m = i < 8 ? 2'h0 : 2'($urandom);
      wr = i < 8 || $urandom_range(1);
      a = {1'($urandom), 1'b0, 2'($urandom), 5'h0, c};
      sdc_ctrl_model_i.cmd(1'b1, wr ? CMD_WRITE : CMD_READ, b, a, m, d);
      if (wr) begin
        mem[c] = (mem[c] & lanes(m)) | (d & ~lanes(m));
        repeat (2) @(negedge clk);
      end else begin
        repeat (3) @(negedge clk);
        `CHK(dq_oe, ~m)
        `CHK(dq_out & lanes(~m), mem[c] & lanes(~m))
      end
    end
    // two-beat burst at latency 3: column counter steps, second word follows the first
    sdc_ctrl_model_i.cmd(1'b1, CMD_LOAD_MODE, 2'h0, 12'h031, 2'h0, 16'h0);
    sdc_ctrl_model_i.cmd(1'b1, CMD_READ, b, 12'h002, 2'h0, 16'h0);
    repeat (4) @(negedge clk);
    `CHK(dq_out, mem[2])
    @(negedge clk);
    `CHK({dq_oe, dq_out}, {2'h3, mem[3]})
    // same burst length with auto precharge: row closes after the last beat
    sdc_ctrl_model_i.cmd(1'b1, CMD_READ, b, 12'h400, 2'h0, 16'h0);
    repeat (4) @(negedge clk);
    `CHK(bank_open, 4'h0)
    for (int k = 0; k < 4; k++) sdc_ctrl_model_i.cmd(1'b1, CMD_ACTIVE, 2'(k), row, 2'h0, 16'h0);
    sdc_ctrl_model_i.cmd(1'b1, CMD_PRECHARGE, b, 12'h000, 2'h0, 16'h0);
    repeat (3) @(negedge clk);
    `CHK(bank_open, ~(4'h1 << b))
    sdc_ctrl_model_i.cmd(1'b1, CMD_PRECHARGE, ~b, 12'h400, 2'h0, 16'h0);
    repeat (3) @(negedge clk);
    `CHK(bank_open, 4'h0)
    // low-power entry from idle, via refresh, and with a row open
    pst = '{PS_PRE_PD, PS_SELF_REF, PS_ACT_PD};
    for (int i = 0; i < 3; i++) begin
      if (i == 2) sdc_ctrl_model_i.cmd(1'b1, CMD_ACTIVE, b, row, 2'h0, 16'h0);
      sdc_ctrl_model_i.cmd(1'b0, i == 1 ? CMD_REFRESH : CMD_NOP, b, row, 2'h0, 16'h0);
      repeat (3) @(negedge clk);
      `CHK(power_state, pst[i])
      `CHK(bufs_off, 1'b1)
      sdc_ctrl_model_i.cmd(1'b1, CMD_NOP, b, row, 2'h0, 16'h0);
      repeat (3) @(negedge clk);
      `CHK(power_state, PS_RUN)
    end
    end_sim();
  end
endmodule
